// >>> rtl/plc_consts.svh
// register offsets, reset values and sizes for the line controller
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

// ==========================================================
// sizes
`define PLC_LINES        32
`define PLC_ADDR_BITS    8

// ==========================================================
// register offsets (byte addresses)
`define PLC_OFF_OWN_SET  8'h00
`define PLC_OFF_OWN_CLR  8'h04
`define PLC_OFF_OWN_STAT 8'h08
`define PLC_OFF_DRV_ON   8'h10
`define PLC_OFF_DRV_OFF  8'h14
`define PLC_OFF_DRV_STAT 8'h18
`define PLC_OFF_FLT_ON   8'h20
`define PLC_OFF_FLT_OFF  8'h24
`define PLC_OFF_FLT_STAT 8'h28
`define PLC_OFF_LVL_SET  8'h30
`define PLC_OFF_LVL_CLR  8'h34
`define PLC_OFF_OUT_LVL  8'h38
`define PLC_OFF_PIN_LVL  8'h3c
`define PLC_OFF_IRQ_ON   8'h40
`define PLC_OFF_IRQ_OFF  8'h44
`define PLC_OFF_IRQ_MASK 8'h48
`define PLC_OFF_FLAGS    8'h4c
`define PLC_OFF_PU_OFF   8'h60
`define PLC_OFF_PU_ON    8'h64
`define PLC_OFF_PU_STAT  8'h68
`define PLC_OFF_SEL_A    8'h70
`define PLC_OFF_SEL_B    8'h74
`define PLC_OFF_ALT_STAT 8'h78
`define PLC_OFF_DW_ON    8'ha0
`define PLC_OFF_DW_OFF   8'ha4
`define PLC_OFF_DW_STAT  8'ha8

// ==========================================================
// reset values
`define PLC_RST_ZERO     32'h0000_0000
`define PLC_RST_OWN      32'hffff_ffff
`define PLC_ALL_MUXED    32'hffff_ffff

`endif

// >>> rtl/plc_pkg.sv
// shared types of the parallel line controller
package plc_pkg;

   typedef logic [31:0] plc_word_type;
   typedef logic [7:0]  plc_addr_type;

endpackage

// >>> rtl/plc_glitch_filter.sv
// per-line input filter: passes a level only once it has held two samples
`timescale 1ns/1ns
`include "plc_consts.svh"

module plc_glitch_filter
   import plc_pkg::*;
#(
   parameter int WIDTH = `PLC_LINES
)(
   input  logic             core_clk,
   input  logic             reset_n,
   input  logic             run,
   input  logic [WIDTH-1:0] raw,
   input  logic [WIDTH-1:0] filt_en,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] sample_reg;
   logic [WIDTH-1:0] sample_next;
   logic [WIDTH-1:0] stable_reg;
   logic [WIDTH-1:0] stable_next;

   // ==========================================================
   // filter state
   // a single-edge design cannot see half cycles; one sample of
   // agreement rejects anything shorter than a clock period
   always_comb begin
      sample_next = run ? raw : sample_reg;
      stable_next = stable_reg;
      if (run) begin
         stable_next = (raw & ~(raw ^ sample_reg))
                     | (stable_reg & (raw ^ sample_reg));
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sample_reg <= '0;
         stable_reg <= '0;
      end else begin
         sample_reg <= sample_next;
         stable_reg <= stable_next;
      end
   end

   assign level = (filt_en & stable_reg) | (~filt_en & raw);

endmodule

// >>> rtl/plc_top.sv
// parallel line controller: register file, pad muxing, readback, flags
// ==========================================================
// What this block does
// - thirty-two lines, each at the same bit of every register.
// - optional per-line filter drops input pulses shorter than a clock.
// - lines without a peripheral ignore hand-over and read as owned.
// - register writes act whether or not the peripheral clock runs.
// - change detection, interrupt and pin readback need the clock running.
// - pull-up on write clears status bit, off write sets it.
// - pull-up works in any configuration; status resets to zero.
// - ownership set and clear writes; one means controller owns line.
// - ownership reset value is a per-product parameter.
// - first-select write clears, second-select write sets the A/B bit.
// - peripheral inputs always see the pad level.
// - A/B status resets to zero, selecting peripheral A.
// - peripheral-owned lines take drive and level from chosen peripheral.
// - drive on and off writes act on status even when peripheral-owned.
// - level set and clear writes act on output level status always.
// - direct level write changes only unmasked bits.
// - direct-write mask set and clear; resets to zero.
// - pin level readback holds last captured level while clock gated.
// - changes set flags; interrupt ORs masked flags; reading clears.
// - filter affects only readback and change detection.
`timescale 1ns/1ns
`include "plc_consts.svh"

module plc_top
   import plc_pkg::*;
#(
   parameter plc_word_type MUXED_LINES = `PLC_ALL_MUXED,
   parameter plc_word_type OWN_RESET   = `PLC_RST_OWN
)(
   input  logic                  core_clk,
   input  logic                  reset_n,
   input  logic                  periph_clk_en,
   input  plc_addr_type          reg_addr,
   input  plc_word_type          reg_wdata,
   input  logic                  reg_wr,
   input  logic                  reg_rd,
   output plc_word_type          reg_rdata,
   input  plc_word_type          pad_in,
   output plc_word_type          pad_out,
   output plc_word_type          pad_oe,
   output plc_word_type          pad_pullup_en,
   input  plc_word_type          per_a_out,
   input  plc_word_type          per_a_oe,
   input  plc_word_type          per_b_out,
   input  plc_word_type          per_b_oe,
   output plc_word_type          per_in,
   output logic                  change_irq
);

   // ==========================================================
   // helpers
   function automatic logic hit(input logic stb,
                                input plc_addr_type a,
                                input plc_addr_type off);
      return stb && (a == off);
   endfunction

   function automatic plc_word_type upd(input plc_word_type cur,
                                        input logic set_stb,
                                        input logic clr_stb,
                                        input plc_word_type d);
      plc_word_type s;
      plc_word_type c;
      s = set_stb ? d : `PLC_RST_ZERO;
      c = clr_stb ? d : `PLC_RST_ZERO;
      return (cur | s) & ~c;
   endfunction

   // ==========================================================
   // state
   plc_word_type own_reg,      own_next;
   plc_word_type drive_reg,    drive_next;
   plc_word_type filt_reg,     filt_next;
   plc_word_type out_lvl_reg,  out_lvl_next;
   plc_word_type pu_off_reg,   pu_off_next;
   plc_word_type alt_reg,      alt_next;
   plc_word_type dw_reg,       dw_next;
   plc_word_type mask_reg,     mask_next;
   plc_word_type pin_lvl_reg,  pin_lvl_next;
   plc_word_type flags_reg,    flags_next;
   logic         primed_reg,   primed_next;
   plc_word_type rdata_reg,    rdata_next;
   plc_word_type pad_out_reg,  pad_out_next;
   plc_word_type pad_oe_reg,   pad_oe_next;
   plc_word_type own_eff;
   plc_word_type filt_level;
   plc_word_type change;

   // unmuxed lines are always owned by the controller
   assign own_eff = own_reg | ~MUXED_LINES;

   // ==========================================================
   // configuration registers: no dependence on the clock enable
   always_comb begin
      own_next = upd(own_reg,
                     hit(reg_wr, reg_addr, `PLC_OFF_OWN_SET),
                     hit(reg_wr, reg_addr, `PLC_OFF_OWN_CLR),
                     reg_wdata & MUXED_LINES);
      drive_next = upd(drive_reg,
                       hit(reg_wr, reg_addr, `PLC_OFF_DRV_ON),
                       hit(reg_wr, reg_addr, `PLC_OFF_DRV_OFF),
                       reg_wdata);
      filt_next = upd(filt_reg,
                      hit(reg_wr, reg_addr, `PLC_OFF_FLT_ON),
                      hit(reg_wr, reg_addr, `PLC_OFF_FLT_OFF),
                      reg_wdata);
      out_lvl_next = upd(out_lvl_reg,
                         hit(reg_wr, reg_addr, `PLC_OFF_LVL_SET),
                         hit(reg_wr, reg_addr, `PLC_OFF_LVL_CLR),
                         reg_wdata);
      if (hit(reg_wr, reg_addr, `PLC_OFF_OUT_LVL)) begin
         out_lvl_next = (out_lvl_reg & ~dw_reg)
                      | (reg_wdata & dw_reg);
      end
      pu_off_next = upd(pu_off_reg,
                        hit(reg_wr, reg_addr, `PLC_OFF_PU_OFF),
                        hit(reg_wr, reg_addr, `PLC_OFF_PU_ON),
                        reg_wdata);
      alt_next = upd(alt_reg,
                     hit(reg_wr, reg_addr, `PLC_OFF_SEL_B),
                     hit(reg_wr, reg_addr, `PLC_OFF_SEL_A),
                     reg_wdata);
      dw_next = upd(dw_reg,
                    hit(reg_wr, reg_addr, `PLC_OFF_DW_ON),
                    hit(reg_wr, reg_addr, `PLC_OFF_DW_OFF),
                    reg_wdata);
      mask_next = upd(mask_reg,
                      hit(reg_wr, reg_addr, `PLC_OFF_IRQ_ON),
                      hit(reg_wr, reg_addr, `PLC_OFF_IRQ_OFF),
                      reg_wdata);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         own_reg     <= OWN_RESET;
         drive_reg   <= `PLC_RST_ZERO;
         filt_reg    <= `PLC_RST_ZERO;
         out_lvl_reg <= `PLC_RST_ZERO;
         pu_off_reg  <= `PLC_RST_ZERO;
         alt_reg     <= `PLC_RST_ZERO;
         dw_reg      <= `PLC_RST_ZERO;
         mask_reg    <= `PLC_RST_ZERO;
      end else begin
         own_reg     <= own_next;
         drive_reg   <= drive_next;
         filt_reg    <= filt_next;
         out_lvl_reg <= out_lvl_next;
         pu_off_reg  <= pu_off_next;
         alt_reg     <= alt_next;
         dw_reg      <= dw_next;
         mask_reg    <= mask_next;
      end
   end

   // ==========================================================
   // input side: filter, readback, change flags
   plc_glitch_filter #(
      .WIDTH   (`PLC_LINES)
   ) u_filter (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .run      (periph_clk_en),
      .raw      (pad_in),
      .filt_en  (filt_reg),
      .level    (filt_level)
   );

   // peripherals get the raw pad, never the filtered copy
   assign per_in = pad_in;

   always_comb begin
      pin_lvl_next = periph_clk_en ? filt_level : pin_lvl_reg;
      primed_next  = primed_reg | periph_clk_en;
      // the first enabled sample after reset only primes the comparison
      change = (periph_clk_en && primed_reg)
             ? (filt_level ^ pin_lvl_reg) : `PLC_RST_ZERO;
      flags_next = hit(reg_rd, reg_addr, `PLC_OFF_FLAGS)
                 ? `PLC_RST_ZERO : flags_reg;
      // a change in the clearing read cycle survives
      flags_next = flags_next | change;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_lvl_reg <= `PLC_RST_ZERO;
         primed_reg  <= 1'b0;
         flags_reg   <= `PLC_RST_ZERO;
      end else begin
         pin_lvl_reg <= pin_lvl_next;
         primed_reg  <= primed_next;
         flags_reg   <= flags_next;
      end
   end

   assign change_irq = periph_clk_en && |(flags_reg & mask_reg);

   // ==========================================================
   // pad drive, one level flop and one enable flop per line
   always_comb begin
      pad_out_next = pad_out_reg;
      pad_oe_next  = pad_oe_reg;
      for (int i = 0; i < `PLC_LINES; i++) begin
         if (own_eff[i]) begin
            pad_oe_next[i]  = drive_reg[i];
            pad_out_next[i] = out_lvl_reg[i];
         end else if (alt_reg[i]) begin
            pad_oe_next[i]  = per_b_oe[i];
            pad_out_next[i] = per_b_out[i];
         end else begin
            pad_oe_next[i]  = per_a_oe[i];
            pad_out_next[i] = per_a_out[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pad_out_reg <= `PLC_RST_ZERO;
         pad_oe_reg  <= `PLC_RST_ZERO;
      end else begin
         pad_out_reg <= pad_out_next;
         pad_oe_reg  <= pad_oe_next;
      end
   end

   assign pad_out       = pad_out_reg;
   assign pad_oe        = pad_oe_reg;
   assign pad_pullup_en = ~pu_off_reg;

   // ==========================================================
   // register reads
   always_comb begin
      rdata_next = `PLC_RST_ZERO;
      if (reg_rd) begin
         unique case (reg_addr)
            `PLC_OFF_OWN_STAT: rdata_next = own_eff;
            `PLC_OFF_DRV_STAT: rdata_next = drive_reg;
            `PLC_OFF_FLT_STAT: rdata_next = filt_reg;
            `PLC_OFF_OUT_LVL:  rdata_next = out_lvl_reg;
            `PLC_OFF_PIN_LVL:  rdata_next = pin_lvl_reg;
            `PLC_OFF_IRQ_MASK: rdata_next = mask_reg;
            `PLC_OFF_FLAGS:    rdata_next = flags_reg;
            `PLC_OFF_PU_STAT:  rdata_next = pu_off_reg;
            `PLC_OFF_ALT_STAT: rdata_next = alt_reg;
            `PLC_OFF_DW_STAT:  rdata_next = dw_reg;
            default:           rdata_next = `PLC_RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= `PLC_RST_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   plc_word_type oe_ref;
   plc_word_type out_ref;
   assign oe_ref = (own_eff & drive_reg)
                 | (~own_eff & alt_reg & per_b_oe)
                 | (~own_eff & ~alt_reg & per_a_oe);
   assign out_ref = (own_eff & out_lvl_reg)
                  | (~own_eff & alt_reg & per_b_out)
                  | (~own_eff & ~alt_reg & per_a_out);

   sequence s_flag_read;
      reg_rd && (reg_addr == `PLC_OFF_FLAGS);
   endsequence

   sequence s_gated_read;
      s_flag_read ##0 !periph_clk_en;
   endsequence

   property p_own_clear;
      (reg_wr && reg_addr == `PLC_OFF_OWN_CLR)
         |=> ((own_eff & $past(reg_wdata) & MUXED_LINES) == '0);
   endproperty
   a_own_clear: assert property (p_own_clear)
      else $error("ownership clear write did not release lines");

   property p_own_fixed;
      (own_eff & ~MUXED_LINES) == ~MUXED_LINES;
   endproperty
   a_own_fixed: assert property (p_own_fixed)
      else $error("unmuxed line reads as peripheral owned");

   property p_drive_gated;
      (reg_wr && reg_addr == `PLC_OFF_DRV_ON && !periph_clk_en)
         |=> ((drive_reg & $past(reg_wdata)) == $past(reg_wdata));
   endproperty
   a_drive_gated: assert property (p_drive_gated)
      else $error("drive write lost while clock gated");

   property p_pullup_on;
      (reg_wr && reg_addr == `PLC_OFF_PU_ON)
         |=> ((pu_off_reg & $past(reg_wdata)) == '0)
             && ((pad_pullup_en & $past(reg_wdata)) == $past(reg_wdata));
   endproperty
   a_pullup_on: assert property (p_pullup_on)
      else $error("pull-up on write not applied");

   property p_sel_b;
      (reg_wr && reg_addr == `PLC_OFF_SEL_B)
         |=> ((alt_reg & $past(reg_wdata)) == $past(reg_wdata));
   endproperty
   a_sel_b: assert property (p_sel_b)
      else $error("second select write did not set alt bits");

   // the release edge still resets the pad flops, so skip it
   property p_pad_oe;
      reset_n |=> (pad_oe_reg == $past(oe_ref));
   endproperty
   a_pad_oe: assert property (p_pad_oe)
      else $error("pad drive enable not from selected owner");

   property p_pad_out;
      reset_n |=> (pad_out_reg == $past(out_ref));
   endproperty
   a_pad_out: assert property (p_pad_out)
      else $error("pad level not from selected owner");

   property p_direct;
      (reg_wr && reg_addr == `PLC_OFF_OUT_LVL)
         |=> out_lvl_reg == (($past(out_lvl_reg) & ~$past(dw_reg))
                           | ($past(reg_wdata) & $past(dw_reg)));
   endproperty
   a_direct: assert property (p_direct)
      else $error("direct write touched masked bits");

   property p_gated;
      !periph_clk_en |=> $stable(pin_lvl_reg)
                         && ((flags_reg & ~$past(flags_reg)) == '0);
   endproperty
   a_gated: assert property (p_gated)
      else $error("readback or flags moved with clock gated");

   property p_flag_read;
      s_gated_read |=> (flags_reg == '0) ##0 !change_irq;
   endproperty
   a_flag_read: assert property (p_flag_read)
      else $error("flag read did not clear flags");

   property p_per_in;
      per_in == pad_in;
   endproperty
   a_per_in: assert property (p_per_in)
      else $error("peripheral input not the raw pad level");

endmodule

// >>> verification/plc_pad_model.sv
// pads and fixed peripheral functions around the line controller
`timescale 1ns/1ns

module plc_pad_model
   import plc_pkg::*;
#(
   parameter plc_word_type A_OUT = 32'h5555_5555,
   parameter plc_word_type A_OE  = 32'h00ff_00ff,
   parameter plc_word_type B_OUT = 32'haaaa_aaaa,
   parameter plc_word_type B_OE  = 32'hff00_ff00
)(
   input  logic         core_clk,
   input  plc_word_type pad_out,
   input  plc_word_type pad_oe,
   input  plc_word_type pad_pullup_en,
   input  plc_word_type ext_en,
   input  plc_word_type ext_lvl,
   output plc_word_type pad_in,
   output plc_word_type per_a_out,
   output plc_word_type per_a_oe,
   output plc_word_type per_b_out,
   output plc_word_type per_b_oe
);
   plc_word_type float_reg = 32'h0000_0000;

   assign per_a_out = A_OUT;
   assign per_a_oe  = A_OE;
   assign per_b_out = B_OUT;
   assign per_b_oe  = B_OE;

   // ==========================================================
   // pad resolution
   // a line nobody drives and nobody pulls wanders every cycle
   always @(posedge core_clk) begin
      float_reg <= ~float_reg;
   end

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_lvl[i];
         end else if (pad_pullup_en[i]) begin
            pad_in[i] = 1'b1;
         end else begin
            pad_in[i] = float_reg[i];
         end
      end
   end
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the parallel line controller
`timescale 1ns/1ns
`include "plc_consts.svh"

`define CHK(nm, ex, got) begin samples_checked++; \
   if ((got) !== (ex)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module tb_top
   import plc_pkg::*;
;
   // ==========================================================
   // lines 0-3 are plain I/O; line 7 resets to its peripheral
   localparam plc_word_type MUXED  = 32'hffff_fff0;
   localparam plc_word_type OWNRST = 32'hffff_ff7f;
   localparam plc_word_type A_OUT  = 32'h5555_5555;
   localparam plc_word_type A_OE   = 32'h00ff_00ff;
   localparam plc_word_type B_OUT  = 32'haaaa_aaaa;
   localparam plc_word_type B_OE   = 32'hff00_ff00;

   typedef struct packed {
      plc_addr_type wa;
      plc_word_type wd;
      plc_addr_type ra;
      plc_word_type ex;
   } plc_row_type;

   logic         core_clk, reset_n, periph_clk_en, reg_wr, reg_rd;
   logic         change_irq;
   plc_addr_type reg_addr;
   plc_word_type reg_wdata, reg_rdata, pad_in, pad_out, pad_oe;
   plc_word_type pad_pullup_en, per_a_out, per_a_oe, per_b_out;
   plc_word_type per_b_oe, per_in, ext_en, ext_lvl, d;
   int           fails = 0;
   int           samples_checked = 0;

   plc_row_type rows [17] = '{
      '{`PLC_OFF_DRV_ON,   32'h0000_00f0, `PLC_OFF_DRV_STAT, 32'h0000_00f0},
      '{`PLC_OFF_DRV_OFF,  32'h0000_0030, `PLC_OFF_DRV_STAT, 32'h0000_00c0},
      '{`PLC_OFF_LVL_SET,  32'h0000_00ff, `PLC_OFF_OUT_LVL,  32'h0000_00ff},
      '{`PLC_OFF_LVL_CLR,  32'h0000_000f, `PLC_OFF_OUT_LVL,  32'h0000_00f0},
      '{`PLC_OFF_PU_OFF,   32'h0000_ff00, `PLC_OFF_PU_STAT,  32'h0000_ff00},
      '{`PLC_OFF_PU_ON,    32'h0000_0f00, `PLC_OFF_PU_STAT,  32'h0000_f000},
      '{`PLC_OFF_SEL_B,    32'h00f0_0000, `PLC_OFF_ALT_STAT, 32'h00f0_0000},
      '{`PLC_OFF_SEL_A,    32'h0030_0000, `PLC_OFF_ALT_STAT, 32'h00c0_0000},
      '{`PLC_OFF_OWN_CLR,  32'h00f0_000f, `PLC_OFF_OWN_STAT, 32'hff0f_ff7f},
      '{`PLC_OFF_OWN_SET,  32'h0000_0080, `PLC_OFF_OWN_STAT, 32'hff0f_ffff},
      '{`PLC_OFF_DW_ON,    32'h0000_ff00, `PLC_OFF_DW_STAT,  32'h0000_ff00},
      '{`PLC_OFF_DW_OFF,   32'h0000_0f00, `PLC_OFF_DW_STAT,  32'h0000_f000},
      '{`PLC_OFF_OUT_LVL,  32'h0000_a000, `PLC_OFF_OUT_LVL,  32'h0000_a0f0},
      '{`PLC_OFF_FLT_ON,   32'h0000_0002, `PLC_OFF_FLT_STAT, 32'h0000_0002},
      '{`PLC_OFF_IRQ_ON,   32'h0000_0003, `PLC_OFF_IRQ_MASK, 32'h0000_0003},
      '{`PLC_OFF_IRQ_OFF,  32'h0000_0002, `PLC_OFF_IRQ_MASK, 32'h0000_0001},
      '{`PLC_OFF_DRV_STAT, 32'hffff_ffff, 8'h0c,             32'h0000_0000}
   };

   plc_top #(.MUXED_LINES(MUXED), .OWN_RESET(OWNRST)) dut_u (
      .core_clk(core_clk), .reset_n(reset_n),
      .periph_clk_en(periph_clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pullup_en(pad_pullup_en),
      .per_a_out(per_a_out), .per_a_oe(per_a_oe), .per_b_out(per_b_out),
      .per_b_oe(per_b_oe), .per_in(per_in), .change_irq(change_irq));

   plc_pad_model #(.A_OUT(A_OUT), .A_OE(A_OE), .B_OUT(B_OUT),
                   .B_OE(B_OE)) pad_u (
      .core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl),
      .pad_in(pad_in), .per_a_out(per_a_out), .per_a_oe(per_a_oe),
      .per_b_out(per_b_out), .per_b_oe(per_b_oe));

   // ==========================================================
   // bus tasks: one strobe cycle, then one idle edge
   task automatic wr(input plc_addr_type a, input plc_word_type v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input plc_addr_type a, output plc_word_type v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
      @(posedge core_clk);
   endtask

   task automatic rchk(input string nm, input plc_addr_type a,
                       input plc_word_type ex);
      plc_word_type v;
      rd(a, v);
      `CHK(nm, ex, v)
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      #(40 * 5000);
      fails++;
      report_and_stop();
   end

   // ==========================================================
   // main sequence
   initial begin
      reset_n = 1'b0;
      periph_clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      ext_en = 32'hffff_ffff;
      ext_lvl = 32'h0000_0000;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 `CHK("pullup pins", 32'hffff_ffff, pad_pullup_en)
      `CHK("line7 oe", A_OE[7], pad_oe[7])
      `CHK("line7 out", A_OUT[7], pad_out[7])
      rchk("own rst", `PLC_OFF_OWN_STAT, OWNRST);
      rchk("pu rst", `PLC_OFF_PU_STAT, 32'h0000_0000);
      rchk("alt rst", `PLC_OFF_ALT_STAT, 32'h0000_0000);
      rchk("dw rst", `PLC_OFF_DW_STAT, 32'h0000_0000);
      rchk("drv rst", `PLC_OFF_DRV_STAT, 32'h0000_0000);
      $display("test reset values done");

      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         rchk("row", rows[i].ra, rows[i].ex);
      end
      $display("test register rows done");

      @(posedge core_clk);
      #1 `CHK("own oe", 4'hc, pad_oe[7:4])
      `CHK("own out", 4'hf, pad_out[7:4])
      `CHK("gpio oe", 4'h0, pad_oe[3:0])
      `CHK("per oe", {B_OE[23:22], A_OE[21:20]}, pad_oe[23:20])
      `CHK("per out", {B_OUT[23:22], A_OUT[21:20]}, pad_out[23:20])
      `CHK("pullups", ~32'h0000_f000, pad_pullup_en)
      `CHK("per in", pad_in, per_in)
      $display("test pad muxing done");

      rd(`PLC_OFF_FLAGS, d);
      ext_lvl[1] <= 1'b1;
      #1 `CHK("glitch seen", 1'b1, per_in[1])
      @(posedge core_clk);
      ext_lvl[1] <= 1'b0;
      repeat (3) @(posedge core_clk);
      rchk("glitch flags", `PLC_OFF_FLAGS, 32'h0000_0000);
      ext_lvl[0] <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 `CHK("irq up", 1'b1, change_irq)
      rd(`PLC_OFF_PIN_LVL, d);
      `CHK("pin0", 1'b1, d[0])
      rchk("flags0", `PLC_OFF_FLAGS, 32'h0000_0001);
      #1 `CHK("irq clear", 1'b0, change_irq)
      ext_lvl[1] <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 `CHK("irq masked", 1'b0, change_irq)
      rchk("flags1", `PLC_OFF_FLAGS, 32'h0000_0002);
      $display("test flags and filter done");

      ext_lvl[0] <= 1'b0;
      repeat (3) @(posedge core_clk);
      periph_clk_en <= 1'b0;
      ext_lvl[0] <= 1'b1;
      @(posedge core_clk);
      #1 `CHK("irq gated", 1'b0, change_irq)
      rd(`PLC_OFF_PIN_LVL, d);
      `CHK("pin held", 1'b0, d[0])
      wr(`PLC_OFF_DRV_ON, 32'h0000_0100);
      rchk("gated write", `PLC_OFF_DRV_STAT, 32'h0000_01c0);
      rchk("gated flags", `PLC_OFF_FLAGS, 32'h0000_0001);
      periph_clk_en <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(`PLC_OFF_PIN_LVL, d);
      `CHK("pin resumed", 1'b1, d[0])
      $display("test clock gating done");
      report_and_stop();
   end
endmodule
